//--- inc/svs_pkg.sv
package svs_pkg;

  // ==========================================================
  // timing base
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned QUANTUM_NS    = 5000000;
  localparam int unsigned TICK_CYCLES   = QUANTUM_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_CYCLES    = 80;
  localparam int unsigned STEPS_PER_S   = 200;
  localparam int unsigned MAX_STEPS     = 360000;

  // ==========================================================
  // widths
  localparam int unsigned VW    = 16;
  localparam int unsigned OPW   = 19;
  localparam int unsigned RLW   = 15;
  localparam int unsigned KW    = 13;
  localparam int unsigned AW    = 12;
  localparam int unsigned RATW  = 17;
  localparam int unsigned VTW   = 24;
  localparam int unsigned NUMW  = 36;
  localparam int unsigned DENW  = 32;

  // ==========================================================
  // scaling of ratio, hysteresis and inverse time
  localparam int unsigned PCT_UNITY     = 100;
  localparam int unsigned PCT_REL_OVER  = 97;
  localparam int unsigned PCT_REL_UNDER = 103;
  localparam int unsigned RATIO_MAX     = 125000;
  localparam int unsigned INV_NUM_SCALE = 100 * STEPS_PER_S;
  localparam int unsigned PRI_DIV       = 10000;

  // ==========================================================
  // register offsets
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_USET     = 12'h004;
  localparam logic [11:0] OFF_OPDLY    = 12'h008;
  localparam logic [11:0] OFF_KDIAL    = 12'h00c;
  localparam logic [11:0] OFF_AMULT    = 12'h010;
  localparam logic [11:0] OFF_RELDLY   = 12'h014;
  localparam logic [11:0] OFF_VTPRI    = 12'h018;
  localparam logic [11:0] OFF_STATUS   = 12'h01c;
  localparam logic [11:0] OFF_EXPECT   = 12'h020;
  localparam logic [11:0] OFF_REMAIN   = 12'h024;
  localparam logic [11:0] OFF_RATIO    = 12'h028;
  localparam logic [11:0] OFF_PICKPRI  = 12'h02c;

  // ==========================================================
  // values after reset
  localparam logic [VW-1:0]  RST_USET   = 16'h2904;
  localparam logic [OPW-1:0] RST_OPDLY  = 19'h00008;
  localparam logic [KW-1:0]  RST_KDIAL  = 13'h0005;
  localparam logic [AW-1:0]  RST_AMULT  = 12'h064;
  localparam logic [RLW-1:0] RST_RELDLY = 15'h000c;
  localparam logic [VTW-1:0] RST_VTPRI  = 24'h00ea60;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SVS_BEH_ON      = 3'h0,
    SVS_BEH_BLOCKED = 3'h1,
    SVS_BEH_TEST    = 3'h2,
    SVS_BEH_TESTBLK = 3'h3,
    SVS_BEH_OFF     = 3'h4
  } svs_beh_t;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_RUN     = 5'h02,
    ST_REL     = 5'h04,
    ST_TRIP    = 5'h08,
    ST_BLOCKED = 5'h10
  } svs_state_t;

  typedef struct packed {
    svs_beh_t       beh;
    logic           under;
    logic           inverse_time_mode;
    logic           del_rel;
    logic           rst_rel;
    logic           cont;
    logic [VW-1:0]  uset;
    logic [OPW-1:0] op_delay;
    logic [KW-1:0]  k_dial;
    logic [AW-1:0]  a_mult;
    logic [RLW-1:0] rel_delay;
    logic [VTW-1:0] vt_pri;
  } svs_cfg_t;

endpackage : svs_pkg

//--- hdl/svs_seq_voltage_stage.sv
`timescale 1ns/100ps
// How it works
// - block input sampled once per processing tick
// - pick-up without block asserts start, timing
// - pick-up under block gives blocked only
// - block after start acts as pick-up reset
// - instant mode trips together with start, one tick after it when leaving blocked
// - definite time trips after set delay
// - inverse time k over ratio power term
// - delay type selects definite or inverse
// - definite delay 5 ms steps, zero instant
// - dial and multiplier defaults, inverse only
// - release delay holds start without trip
// - delayed release option clears start late
// - timer reset after full release delay
// - continue option keeps timer running
// - no trip during release count
// - default holds timer during release
// - publish voltage ratio in hundredths
// - publish pick-up level in primary volts
// - report node behaviour
// - over mode releases below 97 percent
// - under mode releases above 103 percent
module svs_seq_voltage_stage #(
  parameter int unsigned TICK_CYCLES = svs_pkg::TICK_CYCLES
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     ce,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [svs_pkg::VW-1:0]   measured_voltage,
  input  wire logic                     block_in,
  output logic                          start_o,
  output logic                          trip_o,
  output logic                          blocked_o
);

  // ==========================================================
  // elaboration check
  generate
    if (TICK_CYCLES < svs_pkg::DIV_CYCLES) begin : g_bad_tick
      $error("tick too short for the shared divider");
    end
  endgenerate

  // ==========================================================
  // configuration registers
  svs_pkg::svs_cfg_t cfg_q;
  logic              wr_en;
  logic              rd_setup;

  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q.beh       <= svs_pkg::SVS_BEH_ON;
      cfg_q.under     <= 1'b0;
      cfg_q.inverse_time_mode      <= 1'b0;
      cfg_q.del_rel   <= 1'b1;
      cfg_q.rst_rel   <= 1'b1;
      cfg_q.cont      <= 1'b0;
      cfg_q.uset      <= svs_pkg::RST_USET;
      cfg_q.op_delay  <= svs_pkg::RST_OPDLY;
      cfg_q.k_dial    <= svs_pkg::RST_KDIAL;
      cfg_q.a_mult    <= svs_pkg::RST_AMULT;
      cfg_q.rel_delay <= svs_pkg::RST_RELDLY;
      cfg_q.vt_pri    <= svs_pkg::RST_VTPRI;
    end else if (ce && wr_en) begin
      case (paddr)
        svs_pkg::OFF_CTRL: begin
          cfg_q.beh     <= (pwdata[2:0] > 3'h4) ? svs_pkg::SVS_BEH_OFF
                                                : svs_pkg::svs_beh_t'(pwdata[2:0]);
          cfg_q.under   <= pwdata[3];
          cfg_q.inverse_time_mode    <= pwdata[4];
          cfg_q.del_rel <= pwdata[5];
          cfg_q.rst_rel <= pwdata[6];
          cfg_q.cont    <= pwdata[7];
        end
        svs_pkg::OFF_USET:   cfg_q.uset      <= pwdata[svs_pkg::VW-1:0];
        svs_pkg::OFF_OPDLY:  cfg_q.op_delay  <= pwdata[svs_pkg::OPW-1:0];
        svs_pkg::OFF_KDIAL:  cfg_q.k_dial    <= pwdata[svs_pkg::KW-1:0];
        svs_pkg::OFF_AMULT:  cfg_q.a_mult    <= pwdata[svs_pkg::AW-1:0];
        svs_pkg::OFF_RELDLY: cfg_q.rel_delay <= pwdata[svs_pkg::RLW-1:0];
        svs_pkg::OFF_VTPRI:  cfg_q.vt_pri    <= pwdata[svs_pkg::VTW-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // processing tick
  logic [31:0] tick_cnt_q;
  logic        tick;

  assign tick = ce && (tick_cnt_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0;
    end else if (ce) begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // ==========================================================
  // pick-up with built-in hysteresis
  logic [23:0] um_pct;
  logic [23:0] us_pct;
  logic [23:0] us_rel_over;
  logic [23:0] us_rel_under;
  logic        pu_q;
  logic        pu_d;
  logic        off;
  logic        blk_d;
  logic        blk_q;

  assign um_pct       = 24'(measured_voltage) * 24'(svs_pkg::PCT_UNITY);
  assign us_pct       = 24'(cfg_q.uset) * 24'(svs_pkg::PCT_UNITY);
  assign us_rel_over  = 24'(cfg_q.uset) * 24'(svs_pkg::PCT_REL_OVER);
  assign us_rel_under = 24'(cfg_q.uset) * 24'(svs_pkg::PCT_REL_UNDER);
  assign off          = (cfg_q.beh == svs_pkg::SVS_BEH_OFF);

  always_comb begin
    pu_d = pu_q;
    if (!cfg_q.under) begin
      if (um_pct > us_pct) pu_d = 1'b1;
      else if (um_pct < us_rel_over) pu_d = 1'b0;
    end else begin
      if (um_pct < us_pct) pu_d = 1'b1;
      else if (um_pct > us_rel_under) pu_d = 1'b0;
    end
    if (off) pu_d = 1'b0;
  end

  // forced blocking behaviour counts as an active block
  assign blk_d = block_in | (cfg_q.beh == svs_pkg::SVS_BEH_BLOCKED)
                          | (cfg_q.beh == svs_pkg::SVS_BEH_TESTBLK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_q  <= 1'b0;
      blk_q <= 1'b0;
    end else if (tick) begin
      pu_q  <= pu_d;
      blk_q <= blk_d;
    end
  end

  // ==========================================================
  // shared serial divider: ratio first, then inverse time
  logic                     div_busy_q;
  logic                     div_time_q;
  logic [5:0]               div_cnt_q;
  logic [svs_pkg::NUMW-1:0] div_num_q;
  logic [svs_pkg::DENW:0]   div_rem_q;
  logic [svs_pkg::DENW-1:0] div_den_q;
  logic [svs_pkg::DENW:0]   rem_w;
  logic                     ge;
  logic [svs_pkg::NUMW-1:0] quo_w;
  logic [svs_pkg::RATW-1:0] ratio_q;
  logic [svs_pkg::RATW-1:0] ratio_w;
  logic [svs_pkg::RATW-1:0] dev_w;
  logic [svs_pkg::OPW-1:0]  inv_time_q;

  assign rem_w = {div_rem_q[svs_pkg::DENW-1:0], div_num_q[svs_pkg::NUMW-1]};
  assign ge    = rem_w >= {1'b0, div_den_q};
  assign quo_w = {div_num_q[svs_pkg::NUMW-2:0], ge};
  assign ratio_w = (quo_w > 36'(svs_pkg::RATIO_MAX)) ? 17'(svs_pkg::RATIO_MAX)
                                                      : quo_w[svs_pkg::RATW-1:0];
  // deviation of the ratio from unity, in hundredths
  always_comb begin
    dev_w = 17'h0;
    if (!cfg_q.under && ratio_w > 17'(svs_pkg::PCT_UNITY))
      dev_w = ratio_w - 17'(svs_pkg::PCT_UNITY);
    else if (cfg_q.under && ratio_w < 17'(svs_pkg::PCT_UNITY))
      dev_w = 17'(svs_pkg::PCT_UNITY) - ratio_w;
  end

  // power term taken to first order: a*(r-1); exact only near a = 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_busy_q <= 1'b0;
      div_time_q <= 1'b0;
      div_cnt_q  <= 6'h0;
      div_num_q  <= 36'h0;
      div_rem_q  <= 33'h0;
      div_den_q  <= 32'h0;
      ratio_q    <= 17'h0;
      inv_time_q <= 19'h0;
    end else if (ce) begin
      if (tick && !div_busy_q) begin
        div_busy_q <= 1'b1;
        div_time_q <= 1'b0;
        div_cnt_q  <= 6'h0;
        div_rem_q  <= 33'h0;
        div_num_q  <= 36'(um_pct);
        div_den_q  <= 32'(cfg_q.uset);
      end else if (div_busy_q) begin
        div_num_q <= quo_w;
        div_rem_q <= ge ? rem_w - {1'b0, div_den_q} : rem_w;
        div_cnt_q <= div_cnt_q + 6'h1;
        if (div_cnt_q == 6'(svs_pkg::NUMW - 1)) begin
          if (!div_time_q) begin
            ratio_q    <= ratio_w;
            div_time_q <= 1'b1;
            div_cnt_q  <= 6'h0;
            div_rem_q  <= 33'h0;
            div_num_q  <= 36'(cfg_q.k_dial) * 36'(svs_pkg::INV_NUM_SCALE);
            div_den_q  <= 32'(cfg_q.a_mult) * 32'(dev_w);
          end else begin
            div_busy_q <= 1'b0;
            inv_time_q <= (div_den_q == 32'h0 || quo_w > 36'(svs_pkg::MAX_STEPS))
                          ? 19'(svs_pkg::MAX_STEPS) : quo_w[svs_pkg::OPW-1:0];
          end
        end
      end
    end
  end

  // ==========================================================
  // operating target
  logic [svs_pkg::OPW-1:0] tgt;

  assign tgt = cfg_q.inverse_time_mode ? inv_time_q : cfg_q.op_delay;

  // ==========================================================
  // start, timing and release sequencing
  svs_pkg::svs_state_t     state_q;
  logic [svs_pkg::OPW-1:0] op_cnt_q;
  logic [svs_pkg::RLW-1:0] rel_cnt_q;
  logic [svs_pkg::OPW-1:0] op_inc;
  logic [svs_pkg::RLW-1:0] rel_inc;
  logic                    go;

  assign op_inc  = op_cnt_q + 19'h1;
  assign rel_inc = rel_cnt_q + 15'h1;
  assign go      = pu_d & ~blk_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= svs_pkg::ST_IDLE;
      op_cnt_q  <= 19'h0;
      rel_cnt_q <= 15'h0;
    end else if (tick) begin
      if (off) begin
        state_q   <= svs_pkg::ST_IDLE;
        op_cnt_q  <= 19'h0;
        rel_cnt_q <= 15'h0;
      end else begin
        case (state_q)
          svs_pkg::ST_IDLE: begin
            if (pu_d && blk_d) begin
              state_q <= svs_pkg::ST_BLOCKED;
            end else if (go && tgt == 19'h0) begin
              state_q <= svs_pkg::ST_TRIP;
            end else if (go) begin
              state_q <= svs_pkg::ST_RUN;
            end
          end
          svs_pkg::ST_RUN: begin
            if (!go) begin
              rel_cnt_q <= 15'h0;
              if ((!cfg_q.del_rel && !cfg_q.rst_rel) || cfg_q.rel_delay == 15'h0) begin
                state_q  <= svs_pkg::ST_IDLE;
                op_cnt_q <= 19'h0;
              end else begin
                state_q <= svs_pkg::ST_REL;
                if (!cfg_q.rst_rel) op_cnt_q <= 19'h0;
              end
            end else if (op_inc >= tgt) begin
              state_q  <= svs_pkg::ST_TRIP;
              op_cnt_q <= op_inc;
            end else begin
              op_cnt_q <= op_inc;
            end
          end
          svs_pkg::ST_REL: begin
            if (go) begin
              state_q <= svs_pkg::ST_RUN;
            end else if (rel_inc >= cfg_q.rel_delay) begin
              state_q   <= svs_pkg::ST_IDLE;
              op_cnt_q  <= 19'h0;
              rel_cnt_q <= 15'h0;
            end else begin
              rel_cnt_q <= rel_inc;
              if (cfg_q.cont && op_inc < tgt) begin
                op_cnt_q <= op_inc;
              end
            end
          end
          svs_pkg::ST_TRIP: begin
            if (!go) begin
              state_q  <= svs_pkg::ST_IDLE;
              op_cnt_q <= 19'h0;
            end
          end
          svs_pkg::ST_BLOCKED: begin
            if (!pu_d) state_q <= svs_pkg::ST_IDLE;
            else if (!blk_d) state_q <= svs_pkg::ST_RUN;
          end
          default: begin
            state_q  <= svs_pkg::ST_IDLE;
            op_cnt_q <= 19'h0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // stage outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_o   <= 1'b0;
      trip_o    <= 1'b0;
      blocked_o <= 1'b0;
    end else if (ce) begin
      start_o   <= (state_q == svs_pkg::ST_RUN) || (state_q == svs_pkg::ST_TRIP)
                   || (state_q == svs_pkg::ST_REL && cfg_q.del_rel);
      trip_o    <= (state_q == svs_pkg::ST_TRIP);
      blocked_o <= pu_q & blk_q & ~off;
    end
  end

  // ==========================================================
  // published values
  logic [svs_pkg::OPW-1:0] expect_q;
  logic signed [19:0]      remain_q;
  logic [31:0]             pick_pri_q;
  logic [39:0]             pri_prod;

  assign pri_prod = 40'(cfg_q.uset) * 40'(cfg_q.vt_pri);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expect_q   <= 19'h0;
      remain_q   <= 20'sh0;
      pick_pri_q <= 32'h0;
    end else if (ce) begin
      expect_q   <= tgt;
      remain_q   <= signed'(20'(tgt)) - signed'(20'(op_cnt_q));
      pick_pri_q <= 32'(pri_prod / 40'(svs_pkg::PRI_DIV));
    end
  end

  // ==========================================================
  // apb read side; data captured in setup, zero wait state
  logic        hit;
  logic [31:0] rd_d;

  always_comb begin
    hit  = 1'b1;
    rd_d = 32'h0;
    case (paddr)
      svs_pkg::OFF_CTRL:    rd_d = {24'h0, cfg_q.cont, cfg_q.rst_rel, cfg_q.del_rel,
                                    cfg_q.inverse_time_mode, cfg_q.under, cfg_q.beh};
      svs_pkg::OFF_USET:    rd_d = 32'(cfg_q.uset);
      svs_pkg::OFF_OPDLY:   rd_d = 32'(cfg_q.op_delay);
      svs_pkg::OFF_KDIAL:   rd_d = 32'(cfg_q.k_dial);
      svs_pkg::OFF_AMULT:   rd_d = 32'(cfg_q.a_mult);
      svs_pkg::OFF_RELDLY:  rd_d = 32'(cfg_q.rel_delay);
      svs_pkg::OFF_VTPRI:   rd_d = 32'(cfg_q.vt_pri);
      svs_pkg::OFF_STATUS:  rd_d = {25'h0, pu_q, blocked_o, trip_o, start_o,
                                    cfg_q.beh};
      svs_pkg::OFF_EXPECT:  rd_d = 32'(expect_q);
      svs_pkg::OFF_REMAIN:  rd_d = 32'(remain_q);
      svs_pkg::OFF_RATIO:   rd_d = 32'(ratio_q);
      svs_pkg::OFF_PICKPRI: rd_d = pick_pri_q;
      default:              hit  = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (ce && rd_setup) begin
      prdata <= rd_d;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

endmodule : svs_seq_voltage_stage

//--- bench/svs_far_model.sv
`timescale 1ns/100ps
module svs_far_model (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [svs_pkg::VW-1:0] v_cmd,
  input  wire logic                   blk_cmd,
  output logic      [svs_pkg::VW-1:0] measured_voltage,
  output logic                        block_in
);
  // ==========================================================
  // measurement chain, new magnitude lands on an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) measured_voltage <= 16'h2710;
    else measured_voltage <= v_cmd;
  end
  // ==========================================================
  // blocker, bench moves it ticks ahead of any delay expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) block_in <= 1'b0;
    else block_in <= blk_cmd;
  end
endmodule : svs_far_model

//--- bench/svs_stage_assertions.sv
`timescale 1ns/100ps
module svs_stage_assertions #(
  parameter int unsigned TICK_CYCLES = 100
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        start_o,
  input wire logic        trip_o,
  input wire logic        blocked_o
);
  // ==========================================================
  // cycles since start last moved, saturating
  logic        st_q;
  logic [31:0] gap_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= 1'b0;
      gap_q <= 32'h0;
    end else begin
      st_q  <= start_o;
      gap_q <= (start_o != st_q) ? 32'h0 : ((&gap_q) ? gap_q : gap_q + 32'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // stage outputs
  a_trip_has_start: assert property (trip_o |-> start_o)
    else $error("trip without start");
  a_blk_excl_out: assert property (blocked_o |-> !trip_o && (!start_o || $past(start_o)))
    else $error("start rose or trip held while blocked");
  a_trip_after_start: assert property ($rose(trip_o) |-> $past(start_o) || $rose(start_o))
    else $error("trip rose with no start");
  a_start_on_tick: assert property ((start_o != st_q) |-> gap_q >= TICK_CYCLES / 2)
    else $error("start moved between ticks");
  a_trip_on_tick: assert property ($changed(trip_o) |=> $stable(trip_o) [*8])
    else $error("trip moved twice within a tick");
  a_blk_on_tick: assert property ($changed(blocked_o) |=> $stable(blocked_o) [*8])
    else $error("blocked moved twice within a tick");
  // ==========================================================
  // register bus
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  c_trip: cover property ($rose(trip_o));
  c_blocked: cover property ($rose(blocked_o));
  c_release: cover property ($fell(start_o) && !trip_o);
endmodule : svs_stage_assertions

bind svs_seq_voltage_stage svs_stage_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_o(start_o),
  .trip_o(trip_o), .blocked_o(blocked_o));

//--- bench/svs_seq_voltage_stage_tb.sv
`timescale 1ns/100ps
module svs_seq_voltage_stage_tb;
  localparam int unsigned TC = 100;
  logic                   pclk, presetn, ce, psel, penable, pwrite, err;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, rd, seed;
  logic                   pready, pslverr, block_in, blk_cmd, start_o, trip_o, blocked_o;
  logic [svs_pkg::VW-1:0] measured_voltage, v_cmd;
  int                     n_errors, n_tests, n, dly, b;

  svs_seq_voltage_stage #(.TICK_CYCLES(TC)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .measured_voltage(measured_voltage),
    .block_in(block_in), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o));
  svs_far_model i_far (.pclk(pclk), .presetn(presetn), .v_cmd(v_cmd), .blk_cmd(blk_cmd),
    .measured_voltage(measured_voltage), .block_in(block_in));

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [31:0] exp_ratio(input int v);
    return 32'(v * 100 / 10500);
  endfunction : exp_ratio
  // linear power term, exact for multiplier 1.00
  function automatic logic [31:0] exp_inv(input int k, input int a, input int v, input bit u);
    int d;
    d = u ? 100 - int'(exp_ratio(v)) : int'(exp_ratio(v)) - 100;
    return 32'(20000 * k / (a * d));
  endfunction : exp_inv
  task automatic finish_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t word %0h expected %0h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_word(rd, e);
  endtask : rd_chk
  task automatic ticks(input int t);
    repeat (t * TC) @(posedge pclk);
  endtask : ticks
  // sampled on the falling edge, settled after output updates
  task automatic wait_for(input logic tr, input logic lvl, input int lim, output int c);
    c = 0;
    while ((tr ? trip_o : start_o) !== lvl && c < lim) begin
      @(negedge pclk);
      c++;
    end
    if ((tr ? trip_o : start_o) !== lvl) begin
      n_errors++;
      $display("MISMATCH %0t wait limit reached", $time);
    end
  endtask : wait_for

  // ==========================================================
  // clock, watchdog
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, blk_cmd} = 5'h0;
    {paddr, pwdata, n_errors, n_tests} = '0;
    ce = 1'b1;
    seed = 32'h1e;
    v_cmd = 16'h2710;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(svs_pkg::OFF_CTRL, 32'h60);
    rd_chk(svs_pkg::OFF_OPDLY, 32'(svs_pkg::RST_OPDLY));
    rd_chk(svs_pkg::OFF_KDIAL, 32'(svs_pkg::RST_KDIAL));
    rd_chk(svs_pkg::OFF_AMULT, 32'(svs_pkg::RST_AMULT));
    rd_chk(svs_pkg::OFF_RELDLY, 32'(svs_pkg::RST_RELDLY));
    rd_chk(svs_pkg::OFF_PICKPRI, 32'(32'(svs_pkg::RST_USET) * svs_pkg::RST_VTPRI / 10000));
    apb(1'b0, 12'h030, 32'h0);
    chk_bit(err, 1'b1);
    chk_word(rd, 32'h0);
    apb(1'b1, svs_pkg::OFF_RELDLY, 32'h2);
    // definite time, zero and random delays, random magnitude
    for (int i = 0; i < 5; i++) begin
      dly = (i == 0) ? 0 : int'(xs() % 4) + 1;
      apb(1'b1, svs_pkg::OFF_OPDLY, 32'(dly));
      v_cmd <= 16'h2968 + 16'(xs() % 20000);
      wait_for(1'b0, 1'b1, 2 * TC + 5, n);
      wait_for(1'b1, 1'b1, (dly + 1) * TC, n);
      chk_word(32'(n), 32'(dly * TC));
      rd_chk(svs_pkg::OFF_EXPECT, 32'(dly));
      rd_chk(svs_pkg::OFF_REMAIN, 32'h0);
      v_cmd <= 16'h2710;
      ticks(5);
    end
    // over hysteresis
    apb(1'b1, svs_pkg::OFF_OPDLY, 32'h28);
    v_cmd <= 16'h2af8;
    ticks(2);
    v_cmd <= 16'h27d8;
    ticks(2);
    rd_chk(svs_pkg::OFF_STATUS, 32'h48);
    v_cmd <= 16'h2774;
    ticks(2);
    apb(1'b0, svs_pkg::OFF_STATUS, 32'h0);
    chk_bit(rd[6], 1'b0);
    ticks(4);
    // block before and after start
    blk_cmd <= 1'b1;
    v_cmd <= 16'h2af8;
    ticks(2);
    chk_bit(blocked_o, 1'b1);
    chk_bit(start_o, 1'b0);
    blk_cmd <= 1'b0;
    ticks(2);
    chk_bit(start_o, 1'b1);
    blk_cmd <= 1'b1;
    ticks(1);
    chk_bit(start_o, 1'b1);
    ticks(3);
    chk_bit(start_o, 1'b0);
    chk_bit(trip_o, 1'b0);
    {blk_cmd, v_cmd} <= {1'b0, 16'h2710};
    ticks(4);
    // instant release
    apb(1'b1, svs_pkg::OFF_CTRL, 32'h0);
    v_cmd <= 16'h2af8;
    ticks(2);
    v_cmd <= 16'h2710;
    repeat (TC + 3) @(posedge pclk);
    chk_bit(start_o, 1'b0);
    // node behaviour, codes above Off read back as Off
    for (b = 0; b < 8; b++) begin
      apb(1'b1, svs_pkg::OFF_CTRL, 32'h60 | 32'(b));
      apb(1'b0, svs_pkg::OFF_STATUS, 32'h0);
      chk_word(rd & 32'h7, (b > 4) ? 32'h4 : 32'(b));
    end
    v_cmd <= 16'h2af8;
    ticks(2);
    chk_bit(start_o | blocked_o, 1'b0);
    apb(1'b1, svs_pkg::OFF_CTRL, 32'h61);
    ticks(2);
    chk_bit(blocked_o, 1'b1);
    // inverse time, over then under
    apb(1'b1, svs_pkg::OFF_CTRL, 32'h70);
    v_cmd <= 16'h5208;
    ticks(3);
    rd_chk(svs_pkg::OFF_EXPECT, exp_inv(5, 100, 21000, 1'b0));
    rd_chk(svs_pkg::OFF_RATIO, exp_ratio(21000));
    wait_for(1'b1, 1'b1, 12 * TC, n);
    chk_bit(trip_o, 1'b1);
    v_cmd <= 16'h1482;
    apb(1'b1, svs_pkg::OFF_CTRL, 32'h78);
    ticks(3);
    rd_chk(svs_pkg::OFF_EXPECT, exp_inv(5, 100, 5250, 1'b1));
    rd_chk(svs_pkg::OFF_RATIO, exp_ratio(5250));
    v_cmd <= 16'h29cc;
    ticks(2);
    apb(1'b0, svs_pkg::OFF_STATUS, 32'h0);
    chk_bit(rd[6], 1'b1);
    v_cmd <= 16'h2a94;
    ticks(2);
    apb(1'b0, svs_pkg::OFF_STATUS, 32'h0);
    chk_bit(rd[6], 1'b0);
    finish_test();
  end
endmodule : svs_seq_voltage_stage_tb
